// File: rtl/clock_control_defs.svh
`ifndef CLOCK_CONTROL_DEFS_SVH
`define CLOCK_CONTROL_DEFS_SVH

// Register byte addresses
`define CLOCK_RATIO_CONTROL_ADDR 8'h00
`define CLOCK_SOURCE_CONTROL_ADDR 8'h04
`define PLL_CONTROL_ONE_ADDR 8'h08
`define GLOBAL_STATUS_ADDR 8'h0C
`define INTERRUPT_MASK_ADDR 8'h10
`define SOFTWARE_RESET_ADDR 8'h14

// Ratio fields
`define PRIMARY_RATIO_LSB 16
`define SECONDARY_RATIO_LSB 24
`define RATIO_RESET 4'h0

// Clock source control fields
`define OSC_ENABLE_BIT 0
`define PLL_ENABLE_BIT 1
`define DOMAIN0_SOURCE_BIT 8
`define DOMAIN1_SOURCE_BIT 9

// PLL control one fields
`define FAULT_RESET_ENABLE_BIT 29
`define SLIP_REPORT_ENABLE_BIT 30
`define RESET_ON_SLIP_BIT 31

// Global status fields, also the interrupt mask layout
`define REFUSED_FLAG_BIT 0
`define SLIP_FLAG_BIT 8
`define PLL_LOCKED_BIT 16

`define SOFTWARE_RESET_BIT 0

// System reset stretch, in bus clock cycles
`define RESET_HOLD_CYCLES 4'h8
`endif

// File: rtl/clock_control_pkg.sv
package clock_control_pkg;

    typedef enum logic {
        source_oscillator = 1'b0,
        source_pll = 1'b1
    } clock_source_type;

    typedef struct packed {
        logic [3:0] count;
    } divider_state_type;

    typedef struct packed {
        logic active;
        logic [3:0] hold;
    } reset_state_type;

    typedef struct packed {
        logic [3:0] primary_ratio;
        logic [3:0] secondary_ratio;
        logic osc_enable;
        logic pll_enable;
        clock_source_type domain0_source;
        clock_source_type domain1_source;
        logic fault_reset_enable;
        logic slip_report_enable;
        logic reset_on_slip;
        logic slip_flag;
        logic refused_flag;
        logic mask_refused;
        logic mask_slip;
        logic [31:0] read_data;
        logic primary_tick;
        logic secondary_tick;
        logic pll_output_enable;
        logic error_event;
        logic interrupt;
        logic software_reset;
        logic slip_reset;
        logic system_reset;
    } control_state_type;

endpackage

// File: rtl/ratio_divider.sv
`timescale 1ns/1ps
`include "clock_control_defs.svh"

// Divides the bus clock by ratio + 1, but only ever ticks where allow is high.
module ratio_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic restart,
    input wire logic allow,
    input wire logic [3:0] ratio,
    // Output
    output logic tick
);
    clock_control_pkg::divider_state_type state;
    clock_control_pkg::divider_state_type next_state;

    // Waiting for allow is what makes a slow clock a whole multiple of a fast one
    assign tick = !restart && (state.count >= ratio) && allow;

    always_comb begin
        next_state = state;
        if (restart || tick) begin
            next_state.count = 4'h0;
        end else if (state.count != 4'hF) begin
            next_state.count = state.count + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '{count: 4'h0};
        end else begin
            state <= next_state;
        end
    end
endmodule

// File: rtl/system_reset_collector.sv
`timescale 1ns/1ps
`include "clock_control_defs.svh"

// Gathers every system reset cause and stretches it by a fixed number of cycles.
module system_reset_collector (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic reset,
    // Causes
    input wire logic fault_request,
    input wire logic software_request,
    input wire logic watchdog_request,
    input wire logic debug_request,
    input wire logic system_reset_pin_n,
    // Result
    output logic active
);
    clock_control_pkg::reset_state_type state;
    clock_control_pkg::reset_state_type next_state;
    logic cause;

    assign active = state.active;

    always_comb begin
        cause = fault_request || software_request || watchdog_request
            || debug_request || !system_reset_pin_n;
        next_state = state;
        if (cause) begin
            next_state.active = 1'b1;
            next_state.hold = `RESET_HOLD_CYCLES;
        end else if (state.hold != 4'h0) begin
            next_state.hold = state.hold - 4'h1;
        end else begin
            next_state.active = 1'b0;
        end
    end

    // Power-on reset itself also counts as a system reset
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '{active: 1'b1, hold: `RESET_HOLD_CYCLES};
        end else begin
            state <= next_state;
        end
    end
endmodule

// File: rtl/clock_ratio_and_pll_slip_control.sv
`timescale 1ns/1ps
`include "clock_control_defs.svh"

module clock_ratio_and_pll_slip_control (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [31:0] read_data,
    // PLL and oscillator monitors
    input wire logic pll_slip_detect,
    input wire logic pll_locked,
    input wire logic oscillator_fault,
    // Other reset causes
    input wire logic watchdog_reset_request,
    input wire logic debug_reset_request,
    input wire logic system_reset_pin_n,
    // Derived peripheral clock strobes
    output logic primary_peripheral_clock,
    output logic secondary_peripheral_clock,
    // Clock sources
    output logic oscillator_enable,
    output logic pll_enable,
    output logic pll_output_enable,
    output logic domain0_uses_pll,
    output logic domain1_uses_pll,
    // Events
    output logic error_event,
    output logic system_reset,
    output logic interrupt
);
    clock_control_pkg::control_state_type state;
    clock_control_pkg::control_state_type next_state;

    logic system_reset_active;
    logic control_clear;
    logic primary_tick;
    logic secondary_tick;
    logic ratio_write;
    logic source_write;
    logic refuse;
    logic req_osc;
    logic req_pll;
    clock_control_pkg::clock_source_type req_domain0;
    clock_control_pkg::clock_source_type req_domain1;
    logic osc_users;
    logic pll_users;

    // Every system reset clears the system control registers as well
    assign control_clear = reset || system_reset_active;

    // A new ratio restarts both dividers in step, so it acts at once and stays aligned
    assign ratio_write = write_strobe && (address == `CLOCK_RATIO_CONTROL_ADDR);
    assign source_write = write_strobe && (address == `CLOCK_SOURCE_CONTROL_ADDR);

    ratio_divider secondary_divider (
        .clk(clk),
        .reset(reset),
        .restart(control_clear || ratio_write),
        .allow(1'b1),
        .ratio(state.secondary_ratio),
        .tick(secondary_tick)
    );

    // The primary divider may tick only together with the secondary one
    ratio_divider primary_divider (
        .clk(clk),
        .reset(reset),
        .restart(control_clear || ratio_write),
        .allow(secondary_tick),
        .ratio(state.primary_ratio),
        .tick(primary_tick)
    );

    system_reset_collector reset_collector (
        .clk(clk),
        .reset(reset),
        .fault_request(state.slip_reset || (oscillator_fault && state.fault_reset_enable)),
        .software_request(state.software_reset),
        .watchdog_request(watchdog_reset_request),
        .debug_request(debug_reset_request),
        .system_reset_pin_n(system_reset_pin_n),
        .active(system_reset_active)
    );

    assign read_data = state.read_data;
    assign primary_peripheral_clock = state.primary_tick;
    assign secondary_peripheral_clock = state.secondary_tick;
    assign oscillator_enable = state.osc_enable;
    assign pll_enable = state.pll_enable;
    assign pll_output_enable = state.pll_output_enable;
    assign domain0_uses_pll = (state.domain0_source == clock_control_pkg::source_pll);
    assign domain1_uses_pll = (state.domain1_source == clock_control_pkg::source_pll);
    assign error_event = state.error_event;
    assign system_reset = state.system_reset;
    assign interrupt = state.interrupt;

    // Source request checks
    always_comb begin
        req_osc = write_data[`OSC_ENABLE_BIT];
        req_pll = write_data[`PLL_ENABLE_BIT];
        req_domain0 = clock_control_pkg::clock_source_type'(write_data[`DOMAIN0_SOURCE_BIT]);
        req_domain1 = clock_control_pkg::clock_source_type'(write_data[`DOMAIN1_SOURCE_BIT]);
        // The oscillator counts as used while any PLL is enabled, stable or not
        osc_users = (req_domain0 == clock_control_pkg::source_oscillator)
            || (req_domain1 == clock_control_pkg::source_oscillator)
            || state.pll_enable || req_pll;
        pll_users = (req_domain0 == clock_control_pkg::source_pll)
            || (req_domain1 == clock_control_pkg::source_pll);
        refuse = 1'b0;
        if (state.osc_enable && !req_osc && osc_users) begin
            refuse = 1'b1;
        end
        if (!req_osc && pll_users) begin
            refuse = 1'b1;
        end
        if (state.pll_enable && !req_pll && pll_users) begin
            refuse = 1'b1;
        end
        // Selecting a disabled, unlocked or slipped PLL would hand a domain no clock
        if (pll_users && (!req_pll || !pll_locked || state.slip_flag)) begin
            refuse = 1'b1;
        end
    end

    always_comb begin
        next_state = state;
        next_state.error_event = 1'b0;
        next_state.software_reset = 1'b0;
        next_state.slip_reset = 1'b0;
        next_state.read_data = 32'h0000_0000;
        next_state.primary_tick = primary_tick;
        next_state.secondary_tick = secondary_tick;
        next_state.system_reset = system_reset_active;

        if (write_strobe) begin
            unique case (address)
                `CLOCK_RATIO_CONTROL_ADDR: begin
                    next_state.primary_ratio = write_data[`PRIMARY_RATIO_LSB +: 4];
                    next_state.secondary_ratio = write_data[`SECONDARY_RATIO_LSB +: 4];
                end
                `CLOCK_SOURCE_CONTROL_ADDR: begin
                    if (refuse) begin
                        next_state.refused_flag = 1'b1;
                    end else begin
                        next_state.osc_enable = req_osc;
                        next_state.pll_enable = req_pll;
                        next_state.domain0_source = req_domain0;
                        next_state.domain1_source = req_domain1;
                    end
                end
                `PLL_CONTROL_ONE_ADDR: begin
                    next_state.fault_reset_enable = write_data[`FAULT_RESET_ENABLE_BIT];
                    next_state.slip_report_enable = write_data[`SLIP_REPORT_ENABLE_BIT];
                    next_state.reset_on_slip = write_data[`RESET_ON_SLIP_BIT];
                end
                `GLOBAL_STATUS_ADDR: begin
                    if (write_data[`REFUSED_FLAG_BIT]) begin
                        next_state.refused_flag = 1'b0;
                    end
                    if (write_data[`SLIP_FLAG_BIT]) begin
                        next_state.slip_flag = 1'b0;
                    end
                end
                `INTERRUPT_MASK_ADDR: begin
                    next_state.mask_refused = write_data[`REFUSED_FLAG_BIT];
                    next_state.mask_slip = write_data[`SLIP_FLAG_BIT];
                end
                `SOFTWARE_RESET_ADDR: begin
                    next_state.software_reset = write_data[`SOFTWARE_RESET_BIT];
                end
                default: begin
                end
            endcase
        end

        // A refused write in the same cycle as its clear still leaves the flag set
        if (source_write && refuse) begin
            next_state.refused_flag = 1'b1;
        end

        // Slip handling comes last so it wins over any clear or selection in this cycle
        if (pll_slip_detect) begin
            next_state.slip_flag = 1'b1;
            if (state.pll_enable || next_state.pll_enable) begin
                next_state.domain0_source = clock_control_pkg::source_oscillator;
                next_state.domain1_source = clock_control_pkg::source_oscillator;
            end
            next_state.error_event = state.slip_report_enable;
            next_state.slip_reset = state.reset_on_slip;
        end

        // Gate the PLL off from the slip onward until the flag is cleared
        next_state.pll_output_enable = state.pll_enable && pll_locked
            && !next_state.slip_flag && !pll_slip_detect;

        next_state.interrupt = (next_state.refused_flag && next_state.mask_refused)
            || (next_state.slip_flag && next_state.mask_slip);

        if (read_strobe) begin
            unique case (address)
                `CLOCK_RATIO_CONTROL_ADDR: begin
                    next_state.read_data[`PRIMARY_RATIO_LSB +: 4] = state.primary_ratio;
                    next_state.read_data[`SECONDARY_RATIO_LSB +: 4] = state.secondary_ratio;
                end
                `CLOCK_SOURCE_CONTROL_ADDR: begin
                    next_state.read_data[`OSC_ENABLE_BIT] = state.osc_enable;
                    next_state.read_data[`PLL_ENABLE_BIT] = state.pll_enable;
                    next_state.read_data[`DOMAIN0_SOURCE_BIT] = state.domain0_source;
                    next_state.read_data[`DOMAIN1_SOURCE_BIT] = state.domain1_source;
                end
                `PLL_CONTROL_ONE_ADDR: begin
                    next_state.read_data[`FAULT_RESET_ENABLE_BIT] = state.fault_reset_enable;
                    next_state.read_data[`SLIP_REPORT_ENABLE_BIT] = state.slip_report_enable;
                    next_state.read_data[`RESET_ON_SLIP_BIT] = state.reset_on_slip;
                end
                `GLOBAL_STATUS_ADDR: begin
                    next_state.read_data[`REFUSED_FLAG_BIT] = state.refused_flag;
                    next_state.read_data[`SLIP_FLAG_BIT] = state.slip_flag;
                    next_state.read_data[`PLL_LOCKED_BIT] = pll_locked;
                end
                `INTERRUPT_MASK_ADDR: begin
                    next_state.read_data[`REFUSED_FLAG_BIT] = state.mask_refused;
                    next_state.read_data[`SLIP_FLAG_BIT] = state.mask_slip;
                end
                default: begin
                end
            endcase
        end
    end

    // System resets reload every flop here: the system reset flop with 1, the tick flops and the rest with their reset values
    always_ff @(posedge clk) begin
        if (control_clear) begin
            state <= '{
                primary_ratio: `RATIO_RESET,
                secondary_ratio: `RATIO_RESET,
                osc_enable: 1'b1,
                pll_enable: 1'b0,
                domain0_source: clock_control_pkg::source_oscillator,
                domain1_source: clock_control_pkg::source_oscillator,
                fault_reset_enable: 1'b0,
                slip_report_enable: 1'b0,
                reset_on_slip: 1'b0,
                slip_flag: 1'b0,
                refused_flag: 1'b0,
                mask_refused: 1'b0,
                mask_slip: 1'b0,
                read_data: 32'h0000_0000,
                primary_tick: 1'b0,
                secondary_tick: 1'b0,
                pll_output_enable: 1'b0,
                error_event: 1'b0,
                interrupt: 1'b0,
                software_reset: 1'b0,
                slip_reset: 1'b0,
                system_reset: 1'b1
            };
        end else begin
            state <= next_state;
        end
    end
endmodule

// File: tb/clock_control_asserts.sv
`timescale 1ns/1ps
`include "clock_control_defs.svh"

module clock_control_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic [31:0] read_data,
    // Monitors and causes
    input wire logic pll_slip_detect,
    input wire logic watchdog_reset_request,
    input wire logic debug_reset_request,
    input wire logic system_reset_pin_n,
    // Outputs under watch
    input wire logic primary_peripheral_clock,
    input wire logic secondary_peripheral_clock,
    input wire logic oscillator_enable,
    input wire logic pll_enable,
    input wire logic pll_output_enable,
    input wire logic domain0_uses_pll,
    input wire logic domain1_uses_pll,
    input wire logic error_event,
    input wire logic system_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    read_idle_a: assert property (!$past(read_strobe) |-> read_data == 32'h0000_0000)
        else $error("read data not idle");
    edge_align_a: assert property (
        primary_peripheral_clock |-> secondary_peripheral_clock)
        else $error("primary strobe without secondary");
    // Two cycles of margin: the dividers restart as the internal reset drops
    reset_quiet_a: assert property (
        system_reset && $past(system_reset) && $past(system_reset, 2)
        |-> !primary_peripheral_clock && !secondary_peripheral_clock)
        else $error("strobe during system reset");
    reset_cause_a: assert property (
        watchdog_reset_request || debug_reset_request || !system_reset_pin_n
        |-> ##[1:3] system_reset)
        else $error("reset cause ignored");
    pll_user_a: assert property (
        domain0_uses_pll || domain1_uses_pll |-> pll_enable && oscillator_enable)
        else $error("domain on a disabled source");
    osc_user_a: assert property (pll_enable |-> oscillator_enable)
        else $error("oscillator off under running pll");
    slip_switch_a: assert property (
        pll_slip_detect && !system_reset |=> !domain0_uses_pll && !domain1_uses_pll)
        else $error("domain left on slipped pll");
    slip_gate_a: assert property (
        pll_slip_detect && !system_reset |=> !pll_output_enable)
        else $error("pll output not gated after slip");
    error_cause_a: assert property (error_event |-> $past(pll_slip_detect))
        else $error("error event without slip");
    ratio_zero_a: assert property (
        write_strobe && !system_reset && address == `CLOCK_RATIO_CONTROL_ADDR
        && write_data[27:24] == 4'h0 && write_data[19:16] == 4'h0
        |-> ##2 primary_peripheral_clock && secondary_peripheral_clock)
        else $error("zero ratios not at bus rate");
endmodule

bind clock_ratio_and_pll_slip_control clock_control_asserts clock_control_asserts_i (
    .clk(clk), .reset(reset), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .pll_slip_detect(pll_slip_detect), .watchdog_reset_request(watchdog_reset_request),
    .debug_reset_request(debug_reset_request), .system_reset_pin_n(system_reset_pin_n),
    .primary_peripheral_clock(primary_peripheral_clock),
    .secondary_peripheral_clock(secondary_peripheral_clock),
    .oscillator_enable(oscillator_enable), .pll_enable(pll_enable),
    .pll_output_enable(pll_output_enable), .domain0_uses_pll(domain0_uses_pll),
    .domain1_uses_pll(domain1_uses_pll), .error_event(error_event),
    .system_reset(system_reset));

// File: tb/peripheral_model.sv
`timescale 1ns/1ps

// Peripherals on the derived strobes; counts kept across system resets
// so that a phase slip after any reset still shows up
module peripheral_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Derived strobes
    input wire logic primary_tick,
    input wire logic secondary_tick,
    // Observed counts
    output logic [15:0] primary_count,
    output logic [15:0] secondary_count,
    output logic [15:0] misaligned_count
);
    always_ff @(posedge clk) begin
        if (reset) begin
            primary_count <= 16'h0000;
            secondary_count <= 16'h0000;
            misaligned_count <= 16'h0000;
        end else begin
            primary_count <= primary_count + {15'h0000, primary_tick};
            secondary_count <= secondary_count + {15'h0000, secondary_tick};
            misaligned_count <= misaligned_count + {15'h0000, primary_tick & ~secondary_tick};
        end
    end
endmodule

// File: tb/tb_clock_ratio_and_pll_slip_control.sv
`timescale 1ns/1ps
`include "clock_control_defs.svh"

module tb_clock_ratio_and_pll_slip_control;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] address = 8'h00;
    logic [31:0] write_data = 32'h0000_0000;
    logic write_strobe = 1'b0;
    logic read_strobe = 1'b0;
    logic pll_slip_detect = 1'b0;
    logic pll_locked = 1'b0;
    logic oscillator_fault = 1'b0;
    logic watchdog_reset_request = 1'b0;
    logic debug_reset_request = 1'b0;
    logic system_reset_pin_n = 1'b1;
    logic [31:0] read_data;
    logic primary, secondary, osc_en, pll_en, pll_out, dom0, dom1, error_event;
    logic system_reset, interrupt;
    logic [15:0] prim_count, sec_count, bad_count, p0, s0;
    logic [31:0] rdata;
    int miscompares = 0;
    int num_checks = 0;

    clock_ratio_and_pll_slip_control clock_ratio_and_pll_slip_control_i (
        .clk(clk), .reset(reset), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .pll_slip_detect(pll_slip_detect), .pll_locked(pll_locked),
        .oscillator_fault(oscillator_fault), .watchdog_reset_request(watchdog_reset_request),
        .debug_reset_request(debug_reset_request), .system_reset_pin_n(system_reset_pin_n),
        .primary_peripheral_clock(primary), .secondary_peripheral_clock(secondary),
        .oscillator_enable(osc_en), .pll_enable(pll_en), .pll_output_enable(pll_out),
        .domain0_uses_pll(dom0), .domain1_uses_pll(dom1), .error_event(error_event),
        .system_reset(system_reset), .interrupt(interrupt));
    peripheral_model peripheral_model_i (
        .clk(clk), .reset(reset), .primary_tick(primary), .secondary_tick(secondary),
        .primary_count(prim_count), .secondary_count(sec_count), .misaligned_count(bad_count));

    initial begin
        forever #5 clk = ~clk;
    end

    task results;
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clk);
        write_strobe <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a);
        @(posedge clk);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clk);
        read_strobe <= 1'b0;
        #1;
        rdata = read_data;
    endtask

    task wait_sys(input logic level);
        int n;
        n = 0;
        while (system_reset !== level && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (system_reset !== level) begin
            miscompares++;
            results();
        end
    endtask

    task count_ticks(input int cycles, input logic [15:0] ep, input logic [15:0] es);
        p0 = prim_count;
        s0 = sec_count;
        repeat (cycles) @(posedge clk);
        #1;
        check({16'h0000, prim_count - p0}, {16'h0000, ep});
        check({16'h0000, sec_count - s0}, {16'h0000, es});
    endtask

    task slip_pulse;
        @(posedge clk);
        pll_slip_detect <= 1'b1;
        @(posedge clk);
        pll_slip_detect <= 1'b0;
        #1;
    endtask

    task reset_values;
        rd(`CLOCK_RATIO_CONTROL_ADDR);
        check(rdata, 32'h0000_0000);
        rd(`CLOCK_SOURCE_CONTROL_ADDR);
        check(rdata, 32'h0000_0001);
        rd(`GLOBAL_STATUS_ADDR);
        check(rdata, 32'h0000_0000);
        rd(8'h20);
        check(rdata, 32'h0000_0000);
        count_ticks(8, 16'h0008, 16'h0008);
    endtask

    // Divide by four on purpose: the slow case is where alignment used to be lost
    task ratio_steps;
        wr(`CLOCK_RATIO_CONTROL_ADDR, 32'h0103_0000);
        rd(`CLOCK_RATIO_CONTROL_ADDR);
        check(rdata, 32'h0103_0000);
        count_ticks(16, 16'h0004, 16'h0008);
        wr(`CLOCK_RATIO_CONTROL_ADDR, 32'h0003_0000);
        rd(`CLOCK_RATIO_CONTROL_ADDR);
        wr(`CLOCK_RATIO_CONTROL_ADDR, 32'h0000_0000);
        rd(`CLOCK_RATIO_CONTROL_ADDR);
        wr(`CLOCK_RATIO_CONTROL_ADDR, 32'h0001_0000);
        rd(`CLOCK_RATIO_CONTROL_ADDR);
        count_ticks(8, 16'h0004, 16'h0008);
        wr(`CLOCK_RATIO_CONTROL_ADDR, 32'h0000_0000);
        rd(`CLOCK_RATIO_CONTROL_ADDR);
        check(rdata, 32'h0000_0000);
        count_ticks(8, 16'h0008, 16'h0008);
    endtask

    task source_refusal;
        wr(`CLOCK_SOURCE_CONTROL_ADDR, 32'h0000_0003);
        wr(`CLOCK_SOURCE_CONTROL_ADDR, 32'h0000_0002);
        rd(`CLOCK_SOURCE_CONTROL_ADDR);
        check(rdata, 32'h0000_0003);
        rd(`GLOBAL_STATUS_ADDR);
        check(rdata, 32'h0000_0001);
        wr(`GLOBAL_STATUS_ADDR, 32'h0000_0001);
        pll_locked <= 1'b1;
        wr(`CLOCK_SOURCE_CONTROL_ADDR, 32'h0000_0203);
        wr(`CLOCK_SOURCE_CONTROL_ADDR, 32'h0000_0202);
        rd(`CLOCK_SOURCE_CONTROL_ADDR);
        check(rdata, 32'h0000_0203);
        check({27'h0000_0000, pll_en, dom0, osc_en, pll_out, dom1}, 32'h0000_0017);
        rd(`GLOBAL_STATUS_ADDR);
        check(rdata, 32'h0001_0001);
        wr(`GLOBAL_STATUS_ADDR, 32'h0000_0001);
    endtask

    task slip_response;
        wr(`PLL_CONTROL_ONE_ADDR, 32'h4000_0000);
        wr(`INTERRUPT_MASK_ADDR, 32'h0000_0100);
        rd(`GLOBAL_STATUS_ADDR);
        check({31'h0000_0000, interrupt}, 32'h0000_0000);
        slip_pulse();
        check({28'h0000_0000, dom0, error_event, dom1, pll_out}, 32'h0000_0004);
        @(posedge clk);
        #1;
        check({30'h0000_0000, error_event, interrupt}, 32'h0000_0001);
        rd(`GLOBAL_STATUS_ADDR);
        check(rdata, 32'h0001_0100);
        wr(`CLOCK_SOURCE_CONTROL_ADDR, 32'h0000_0203);
        rd(`CLOCK_SOURCE_CONTROL_ADDR);
        check(rdata, 32'h0000_0003);
        wr(`GLOBAL_STATUS_ADDR, 32'h0000_0101);
        rd(`GLOBAL_STATUS_ADDR);
        check(rdata, 32'h0001_0000);
        check({31'h0000_0000, interrupt}, 32'h0000_0000);
        wr(`CLOCK_SOURCE_CONTROL_ADDR, 32'h0000_0203);
        rd(`CLOCK_SOURCE_CONTROL_ADDR);
        check(rdata, 32'h0000_0203);
        check({31'h0000_0000, pll_out}, 32'h0000_0001);
    endtask

    task slip_reset;
        wr(`PLL_CONTROL_ONE_ADDR, 32'h8000_0000);
        slip_pulse();
        wait_sys(1'b1);
        wait_sys(1'b0);
        rd(`PLL_CONTROL_ONE_ADDR);
        check(rdata, 32'h0000_0000);
        rd(`CLOCK_SOURCE_CONTROL_ADDR);
        check(rdata, 32'h0000_0001);
    endtask

    // Causes in turn: watchdog, debug, software, oscillator fault, reset pin
    task reset_causes;
        for (int i = 0; i < 5; i++) begin
            wr(`PLL_CONTROL_ONE_ADDR, 32'h2000_0000);
            if (i == 2) begin
                wr(`SOFTWARE_RESET_ADDR, 32'h0000_0001);
            end else begin
                @(posedge clk);
                case (i)
                    0: watchdog_reset_request <= 1'b1;
                    1: debug_reset_request <= 1'b1;
                    3: oscillator_fault <= 1'b1;
                    default: system_reset_pin_n <= 1'b0;
                endcase
                @(posedge clk);
                watchdog_reset_request <= 1'b0;
                debug_reset_request <= 1'b0;
                oscillator_fault <= 1'b0;
                system_reset_pin_n <= 1'b1;
            end
            #1;
            wait_sys(1'b1);
            wait_sys(1'b0);
            rd(`PLL_CONTROL_ONE_ADDR);
            check(rdata, 32'h0000_0000);
        end
    endtask

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        wait_sys(1'b0);
        reset_values();
        source_refusal();
        slip_response();
        slip_reset();
        reset_causes();
        ratio_steps();
        check({16'h0000, bad_count}, 32'h0000_0000);
        results();
    end
endmodule
